/* File: rdc_device.sv */
// Regulator control device end: control register, dropout interrupt, reset sequencing
// Functional notes
// - Regulator enabled after every reset
// - Two output levels via one select
// - Interrupt on dropout when enabled
// - No pending flag; live gated request
// - Firmware waits for stable input first
// - Priority bit provided; firmware sets it
// - Service routine disables interrupt, safe state
// - Dropout bit clears in hardware; poll
// - Calibrate output after every reset
// - High threshold non-POR reset may hang
// - POR restores low threshold, resumes
// - Firmware keeps monitor at low threshold; rdc_ctrl never drives mon_high_i, which comes from outside
// - Bit 7 disable, resets 0
// - Bit 4 level select, resets 1
// - Bit 0 read-only dropout status
// - Bit 6 reads 1; unused read 0
`timescale 1ns/100ps
`default_nettype none
module rdc_device
  import rdc_pkg::*;
(
  input wire logic clk_i, // System clock 40 MHz
  input wire logic rst_i, // Any reset, async active high
  input wire logic por_i, // Reset cause is power-on, valid during rst_i
  input wire logic dropout_cmp_i, // Analog dropout comparator, asynchronous
  input wire logic cal_low_i, // Uncalibrated output below high threshold
  input wire logic mon_high_i, // Supply monitor high threshold request
  output logic reg_off_o, // Regulator disabled
  output logic level_high_o, // Higher output level selected
  output logic cal_run_o, // Calibration in progress
  output logic mon_high_o, // Supply monitor at high threshold
  rdc_if.dev bus // Register port toward the core
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0]
  {
    RDC_ST_CAL = 3'b001,
    RDC_ST_HOLD = 3'b010,
    RDC_ST_RUN = 3'b100
  } rdc_state_t;

  rdc_state_t state_reg;
  rdc_state_t state_next;
  logic [RDC_CNT_W-1:0] cnt_reg;
  logic [7:0] ctrl_reg;
  logic irq_en_reg;
  logic irq_pri_reg;
  logic por_seen_reg;
  logic mon_high_reg;
  logic drop_sync;
  logic cal_low_sync;
  logic irq_reg;
  logic [7:0] rdata_reg;

  rdc_sync3 u_drop_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i (dropout_cmp_i),
    .q_o (drop_sync)
  );

  // The calibration result comes from analog, so it is filtered like the comparator
  rdc_sync3 u_cal_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i (cal_low_i),
    .q_o (cal_low_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  wire cal_done = (cnt_reg == RDC_CNT_W'(RDC_CAL_CYC - 1));
  // Uncalibrated output under a high monitor threshold keeps the part held
  wire hold_hit = mon_high_reg & cal_low_sync & ~por_seen_reg;
  wire running = (state_reg == RDC_ST_RUN);
  wire wr_ctrl = bus.wr & running & (bus.addr == RDC_CTRL_ADDR);
  wire wr_en = bus.wr & running & (bus.addr == RDC_IRQ_EN_ADDR);
  wire wr_pri = bus.wr & running & (bus.addr == RDC_IRQ_PRI_ADDR);
  wire [7:0] ctrl_view = (ctrl_reg & RDC_CTRL_WMASK) | RDC_RSVD_MASK
    | {7'h00, drop_sync};
  wire [7:0] rd_mux = (bus.addr == RDC_CTRL_ADDR) ? ctrl_view
    : (bus.addr == RDC_IRQ_EN_ADDR) ? {7'h00, irq_en_reg}
    : (bus.addr == RDC_IRQ_PRI_ADDR) ? {7'h00, irq_pri_reg} : 8'h00;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RDC_ST_CAL:
        if (cal_done)
          state_next = hold_hit ? RDC_ST_HOLD : RDC_ST_RUN;
      RDC_ST_HOLD:
        state_next = RDC_ST_HOLD;
      RDC_ST_RUN:
        state_next = RDC_ST_RUN;
      default:
        state_next = RDC_ST_CAL;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next values as named wires keep each register block short
  wire [RDC_CNT_W-1:0] cnt_next = cal_done ? cnt_reg : cnt_reg + 1'b1;
  wire [7:0] ctrl_next = wr_ctrl ? (bus.wdata & RDC_CTRL_WMASK) : ctrl_reg;
  wire irq_en_next = wr_en ? bus.wdata[RDC_IRQ_EN_BIT] : irq_en_reg;
  wire irq_pri_next = wr_pri ? bus.wdata[RDC_IRQ_PRI_BIT] : irq_pri_reg;
  // Live request: drops with the condition, nothing is latched
  wire irq_next = irq_en_reg & drop_sync & running;

  //////////////////////////////////////////////////////////////////////////////
  // Calibration restarts from zero on every reset, whatever its cause
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= RDC_ST_CAL;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Writes are refused until calibration ends in run, so firmware starts from reset values
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_reg <= RDC_CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_en_reg <= 1'b0;
      irq_pri_reg <= 1'b0;
    end
    else
    begin
      irq_en_reg <= irq_en_next;
      irq_pri_reg <= irq_pri_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  // Read data lags the address by one cycle; the controller allows for it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_mux;
  end

  // Reset cause is reloaded at every reset; monitor threshold survives all resets except power-on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_seen_reg <= por_i;
      if (por_i)
        mon_high_reg <= 1'b0;
    end
    else
    begin
      // Cause stays known until calibration has chosen hold or run
      if (running)
        por_seen_reg <= 1'b0;
      if (running)
        mon_high_reg <= mon_high_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_off_o <= 1'b0;
      level_high_o <= 1'b1;
      cal_run_o <= 1'b1;
      mon_high_o <= 1'b0;
    end
    else
    begin
      reg_off_o <= ctrl_reg[RDC_OFF_BIT];
      level_high_o <= ctrl_reg[RDC_LEVEL_BIT];
      cal_run_o <= (state_next == RDC_ST_CAL);
      mon_high_o <= mon_high_reg;
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.irq = irq_reg;
  assign bus.irq_pri = irq_pri_reg;
  assign bus.in_reset = ~running;
endmodule // rdc_device
`default_nettype wire

/* File: rdc_pkg.sv */
// Package of constants shared by the regulator control ends
package rdc_pkg;
  localparam logic [7:0] RDC_CTRL_ADDR = 8'hC9;
  localparam logic [7:0] RDC_IRQ_EN_ADDR = 8'hE7;
  localparam logic [7:0] RDC_IRQ_PRI_ADDR = 8'hF7;
  localparam logic [7:0] RDC_HOST_CMD_ADDR = 8'h00;
  localparam logic [7:0] RDC_HOST_STAT_ADDR = 8'h04;
  localparam int RDC_OFF_BIT = 7;
  localparam int RDC_RSVD_BIT = 6;
  localparam int RDC_LEVEL_BIT = 4;
  localparam int RDC_DROP_BIT = 0;
  localparam int RDC_IRQ_EN_BIT = 0;
  localparam int RDC_IRQ_PRI_BIT = 0;
  localparam logic [7:0] RDC_CTRL_RESET = 8'h50;
  localparam logic [7:0] RDC_CTRL_WMASK = 8'hD0;
  localparam logic [7:0] RDC_RSVD_MASK = 8'h40;
  localparam int RDC_CAL_NS = 1000;
  localparam int RDC_CLK_NS = 25;
  localparam int RDC_CAL_CYC = (RDC_CAL_NS + RDC_CLK_NS - 1) / RDC_CLK_NS;
  localparam int RDC_SETTLE_NS = 10000;
  localparam int RDC_SETTLE_CYC = (RDC_SETTLE_NS + RDC_CLK_NS - 1) / RDC_CLK_NS;
  localparam int RDC_CNT_W = 12;
endpackage

/* File: rdc_if.sv */
// Interface joining the regulator logic and its firmware-side controller
`timescale 1ns/100ps
`default_nettype none
interface rdc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  logic irq;
  logic irq_pri;
  logic in_reset;
  modport dev (input addr, input wdata, input wr, output rdata, output irq, output irq_pri,
    output in_reset);
  modport ctl (output addr, output wdata, output wr, input rdata, input irq, input irq_pri,
    input in_reset);
endinterface
`default_nettype wire

/* File: rdc_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rdc_sync3
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic d_i, // Raw asynchronous input
  output logic q_o // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only accept a change once two settled stages agree
      if (s2_reg == s3_reg)
        q_o <= s3_reg;
    end
  end
endmodule // rdc_sync3
`default_nettype wire

/* File: rdc_ctrl.sv */
// Firmware-side controller: Avalon-MM slave for software, drives the register port
`timescale 1ns/100ps
`default_nettype none
module rdc_ctrl
  import rdc_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Async reset
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  output logic safe_mode_o, // Application in safe state
  rdc_if.ctl dev // Register port of the regulator logic
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0]
  {
    RDC_C_IDLE = 4'b0001,
    RDC_C_ARM = 4'b0010,
    RDC_C_POLL = 4'b0100,
    RDC_C_ACK = 4'b1000
  } rdc_cstate_t;

  rdc_cstate_t cst_reg;
  logic [RDC_CNT_W-1:0] settle_reg;
  logic safe_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic arm_req_reg;
  logic [7:0] ctrl_cmd_reg;
  logic cmd_pend_reg;
  logic rd_ctrl_reg;

  wire settled = (settle_reg == RDC_CNT_W'(RDC_SETTLE_CYC));
  wire req = (avs_read | avs_write) & wait_reg;
  wire sel_cmd = (avs_address == RDC_HOST_CMD_ADDR);
  wire sel_stat = (avs_address == RDC_HOST_STAT_ADDR);
  wire [31:0] stat_word = {28'h0000000, dev.in_reset, dev.irq, safe_reg, arm_req_reg};
  wire [31:0] cmd_word = {24'h000000, ctrl_cmd_reg};
  // A host write lands at the edge where the master sees waitrequest low
  wire host_wr = avs_write & ~wait_reg & sel_cmd;
  // Device writes during calibration would be refused, so they wait
  wire fwd_ok = cmd_pend_reg & ~dev.in_reset;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cst_reg <= RDC_C_IDLE;
      settle_reg <= '0;
      safe_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      arm_req_reg <= 1'b0;
      ctrl_cmd_reg <= RDC_CTRL_RESET;
      cmd_pend_reg <= 1'b0;
      rd_ctrl_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= 1'b0;
      if (dev.in_reset)
        settle_reg <= '0;
      else if (!settled)
        settle_reg <= settle_reg + 1'b1;
      // One-cycle answer, then waitrequest high again
      wait_reg <= ~req;
      // Tells whether the device read data now standing came from control
      rd_ctrl_reg <= (addr_reg == RDC_CTRL_ADDR);
      if (req)
        rdata_reg <= sel_cmd ? cmd_word : sel_stat ? stat_word : 32'h00000000;
      case (cst_reg)
        RDC_C_IDLE:
          if (fwd_ok)
          begin
            addr_reg <= RDC_CTRL_ADDR;
            wdata_reg <= ctrl_cmd_reg;
            wr_reg <= 1'b1;
            cmd_pend_reg <= 1'b0;
            cst_reg <= RDC_C_ARM;
          end
        RDC_C_ARM:
          if (arm_req_reg & settled & ~safe_reg)
          begin
            addr_reg <= RDC_IRQ_PRI_ADDR;
            wdata_reg <= 8'h01;
            wr_reg <= 1'b1;
            cst_reg <= RDC_C_ACK;
          end
          else if (dev.irq)
          begin
            addr_reg <= RDC_IRQ_EN_ADDR;
            wdata_reg <= 8'h00;
            wr_reg <= 1'b1;
            safe_reg <= 1'b1;
            cst_reg <= RDC_C_POLL;
          end
          else if (fwd_ok)
          begin
            addr_reg <= RDC_CTRL_ADDR;
            wdata_reg <= ctrl_cmd_reg;
            wr_reg <= 1'b1;
            cmd_pend_reg <= 1'b0;
          end
        RDC_C_ACK:
        begin
          addr_reg <= RDC_IRQ_EN_ADDR;
          wdata_reg <= 8'h01;
          wr_reg <= 1'b1;
          arm_req_reg <= 1'b0;
          cst_reg <= RDC_C_ARM;
        end
        RDC_C_POLL:
        begin
          addr_reg <= RDC_CTRL_ADDR;
          // Re-arm only after the dropout bit reads clear
          if (~dev.rdata[RDC_DROP_BIT] & rd_ctrl_reg)
          begin
            safe_reg <= 1'b0;
            cst_reg <= RDC_C_ACK;
          end
        end
        default:
          cst_reg <= RDC_C_IDLE;
      endcase
      // Placed last so a host command wins over a same-cycle clear
      if (host_wr)
      begin
        ctrl_cmd_reg <= avs_writedata[7:0] | RDC_RSVD_MASK;
        arm_req_reg <= avs_writedata[8];
        cmd_pend_reg <= 1'b1;
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign safe_mode_o = safe_reg;
  assign dev.addr = addr_reg;
  assign dev.wdata = wdata_reg;
  assign dev.wr = wr_reg;
endmodule // rdc_ctrl
`default_nettype wire

/* File: rdc_assertions.sv */
// Concurrent checks on the regulator register port
`timescale 1ns/100ps
`default_nettype none
module rdc_assertions
  import rdc_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic [7:0] rdata_i, // Read data
  input wire logic irq_i, // Dropout request
  input wire logic irq_pri_i, // Request priority
  input wire logic in_reset_i // Held in reset
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] cal_cnt_reg;
  // Saturates so a long hold cannot wrap into a false short count
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      cal_cnt_reg <= 8'h00;
    else if (in_reset_i && cal_cnt_reg != 8'hFF)
      cal_cnt_reg <= cal_cnt_reg + 8'h01;
  sequence ctrl_wr_s;
    wr_i && addr_i == RDC_CTRL_ADDR && !in_reset_i ##1 addr_i == RDC_CTRL_ADDR && !in_reset_i;
  endsequence
  sequence ctrl_rd_s;
    !in_reset_i && !$past(in_reset_i) && $past(addr_i) == RDC_CTRL_ADDR;
  endsequence
  rsvd_bit_a: assert property (ctrl_rd_s |-> rdata_i[RDC_RSVD_BIT])
    else $error("reserved bit read as 0");
  unused_bits_a: assert property (ctrl_rd_s |-> (rdata_i & 8'h2E) == 8'h00)
    else $error("unused bits not 0");
  ctrl_write_a: assert property (ctrl_wr_s |=>
    rdata_i[RDC_OFF_BIT] == $past(wdata_i[RDC_OFF_BIT], 2) &&
    rdata_i[RDC_LEVEL_BIT] == $past(wdata_i[RDC_LEVEL_BIT], 2))
    else $error("control write not read back");
  pri_write_a: assert property (wr_i && addr_i == RDC_IRQ_PRI_ADDR && !in_reset_i
    |=> irq_pri_i == $past(wdata_i[RDC_IRQ_PRI_BIT])) else $error("priority not taken");
  irq_gate_a: assert property (wr_i && addr_i == RDC_IRQ_EN_ADDR && !wdata_i[0] && !in_reset_i
    |=> ##1 !irq_i) else $error("request after disable");
  quiet_reset_a: assert property (in_reset_i |-> !irq_i)
    else $error("request while in reset");
  cal_len_a: assert property ($fell(in_reset_i) |-> cal_cnt_reg >= RDC_CAL_CYC - 1)
    else $error("calibration too short");
  no_reentry_a: assert property (!in_reset_i |=> !in_reset_i)
    else $error("reset hold without reset");
endmodule // rdc_assertions
`default_nettype wire

/* File: regulator_dropout_control_tb_top.sv */
// Testbench joining both regulator control ends
`timescale 1ns/100ps
`default_nettype none
module regulator_dropout_control_tb_top;
  import rdc_pkg::*;
  logic clk_i, rst_i, por_i, dropout_cmp_i, cal_low_i, mon_high_i;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, safe_mode_o;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic reg_off_o, level_high_o, cal_run_o, mon_high_o, seen;
  int failures = 0;
  int comparisons = 0;
  rdc_if rdc_if_inst ();
  rdc_device rdc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .dropout_cmp_i(dropout_cmp_i), .cal_low_i(cal_low_i), .mon_high_i(mon_high_i),
    .reg_off_o(reg_off_o), .level_high_o(level_high_o), .cal_run_o(cal_run_o),
    .mon_high_o(mon_high_o), .bus(rdc_if_inst.dev));
  rdc_ctrl rdc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .safe_mode_o(safe_mode_o), .dev(rdc_if_inst.ctl));
  rdc_assertions rdc_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(rdc_if_inst.addr), .wdata_i(rdc_if_inst.wdata), .wr_i(rdc_if_inst.wr),
    .rdata_i(rdc_if_inst.rdata), .irq_i(rdc_if_inst.irq), .irq_pri_i(rdc_if_inst.irq_pri),
    .in_reset_i(rdc_if_inst.in_reset));
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Leading edge keeps a new request off the edge that released the last one
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++)
      @(posedge clk_i);
    // Ends on an edge so the next stimulus is still driven at the clock
    @(posedge clk_i);
  endtask
  task automatic do_reset(input logic por);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_i <= por;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic t_boot;
    int n;
    #1;
    chk("cal_run", 1, cal_run_o);
    chk("reg_off", 0, reg_off_o);
    chk("level", 1, level_high_o);
    for (n = 0; n < 200 && rdc_if_inst.in_reset !== 1'b0; n++)
      @(posedge clk_i);
    chk("cal_len", 1, n >= RDC_CAL_CYC - 1);
    av(0, 8'h04, 32'h0);
    chk("status", 0, rd[3]);
    av(0, 8'h08, 32'h0);
    chk("unmapped", 0, rd);
  endtask
  task automatic t_ctrl;
    av(1, 8'h00, 32'h80);
    wait_on(reg_off_o, 1, 20);
    chk("reg_off", 1, reg_off_o);
    chk("level", 0, level_high_o);
    av(1, 8'h00, 32'h50);
    wait_on(reg_off_o, 0, 20);
    chk("reg_off", 0, reg_off_o);
    chk("level", 1, level_high_o);
  endtask
  task automatic t_drop;
    av(1, 8'h00, 32'h150);
    wait_on(rdc_if_inst.irq_pri, 1, 600);
    chk("irq_pri", 1, rdc_if_inst.irq_pri);
    repeat (5) @(posedge clk_i);
    dropout_cmp_i <= 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 40 && safe_mode_o !== 1'b1; i++)
    begin
      @(posedge clk_i);
      seen = seen | (rdc_if_inst.irq === 1'b1);
    end
    chk("irq", 1, seen);
    chk("safe", 1, safe_mode_o);
    repeat (5) @(posedge clk_i);
    chk("irq_off", 0, rdc_if_inst.irq);
    av(0, 8'h04, 32'h0);
    chk("st_safe", 1, rd[1]);
    dropout_cmp_i <= 1'b0;
    wait_on(safe_mode_o, 0, 1000);
    chk("rearm", 0, safe_mode_o);
  endtask
  task automatic t_hold;
    mon_high_i <= 1'b1;
    cal_low_i <= 1'b1;
    wait_on(mon_high_o, 1, 20);
    chk("mon_high", 1, mon_high_o);
    do_reset(0);
    wait_on(rdc_if_inst.in_reset, 0, 200);
    chk("hold", 1, rdc_if_inst.in_reset);
    chk("mon_kept", 1, mon_high_o);
    mon_high_i <= 1'b0;
    do_reset(1);
    wait_on(rdc_if_inst.in_reset, 0, 200);
    chk("resume", 0, rdc_if_inst.in_reset);
    chk("mon_low", 0, mon_high_o);
  endtask
  //////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done;
  end
  initial
  begin
    rst_i = 1'b1;
    por_i = 1'b1;
    dropout_cmp_i = 1'b0;
    cal_low_i = 1'b0;
    mon_high_i = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot;
    t_ctrl;
    t_drop;
    t_hold;
    test_done;
  end
endmodule // regulator_dropout_control_tb_top
`default_nettype wire
